// [logic/bhm_top.sv]
// Byte hardware multiplier: 8x8 unsigned product into a held product pair.
// Assumes operands and strobes come from core logic on the same clock.
//
// Overview of operation
// RULE1 - Unsigned 8x8 product completes in one cycle
// RULE2 - Product high and low bytes fill pair
// RULE3 - Multiply leaves arithmetic status flags unchanged
// RULE4 - Operands: working register and named file register
// RULE5 - Software fixes signed 8x8 by subtracting operands
// RULE6 - Software builds 16x16 from four partial products
// RULE7 - Software fixes signed 16x16 by upper-half subtracts
// RULE8 - No sign handling of either operand
// RULE9 - Product bytes held, software reads writes each
`timescale 1ns/1ps

`include "bhm_defs.svh"

module bhm_top
   import bhm_pkg::*;
#(
   parameter int OPND_W = `BHM_OPND_W
) (
   // Clock and reset
   input  wire logic                  I_SYS_CLK,
   input  wire logic                  I_RST,
   // Multiply instruction
   input  wire logic                  I_MUL_EN,
   input  wire logic [OPND_W-1:0]     I_WORK_REG,
   input  wire logic [OPND_W-1:0]     I_FILE_OPND,
   // Software access to the product pair
   input  wire logic                  I_PROD_HI_WE,
   input  wire logic                  I_PROD_LO_WE,
   input  wire logic [OPND_W-1:0]     I_WR_DATA,
   // Status flag updates from other ALU operations
   input  wire logic                  I_FLAG_WE,
   input  wire logic [OPND_W-1:0]     I_FLAG_D,
   // Results
   output logic      [OPND_W-1:0]     O_PRODUCT_HIGH_BYTE,
   output logic      [OPND_W-1:0]     O_PRODUCT_LOW_BYTE,
   output logic      [OPND_W-1:0]     O_ARITH_STATUS,
   output logic                       O_MUL_DONE
);

   logic [OPND_W-1:0]   prod_hi_q;
   logic [OPND_W-1:0]   prod_lo_q;
   logic [OPND_W-1:0]   status_q;
   logic                done_q;
   bhm_src_t            hi_src;
   bhm_src_t            lo_src;

   bhm_mul_if #(.W(OPND_W)) mif ();

   // Operands go straight into the array, so the product is ready in the same cycle
   assign mif.opnd_a = I_WORK_REG;                                       // RULE4
   assign mif.opnd_b = I_FILE_OPND;                                      // RULE4

   bhm_mul_array #(
      .W   (OPND_W)
   ) u_array (
      .mif (mif.array)
   );

   // Same arbitration for both bytes; a write that loses to a multiply is dropped silently
   assign hi_src = bhm_byte_src(I_MUL_EN, I_PROD_HI_WE);
   assign lo_src = bhm_byte_src(I_MUL_EN, I_PROD_LO_WE);

   // High product byte
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         prod_hi_q <= `BHM_BYTE_RST;
      end else begin
         case (hi_src)
            BHM_SRC_MUL: begin
               prod_hi_q <= mif.product[`BHM_HI_MSB:`BHM_HI_LSB];      // RULE2
            end
            BHM_SRC_SW: begin
               prod_hi_q <= I_WR_DATA;                                   // RULE9
            end
            default: begin
               prod_hi_q <= prod_hi_q;                                   // RULE9
            end
         endcase
      end
   end

   // Low product byte
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         prod_lo_q <= `BHM_BYTE_RST;
      end else begin
         case (lo_src)
            BHM_SRC_MUL: begin
               prod_lo_q <= mif.product[`BHM_LO_MSB:`BHM_LO_LSB];      // RULE2
            end
            BHM_SRC_SW: begin
               prod_lo_q <= I_WR_DATA;                                   // RULE9
            end
            default: begin
               prod_lo_q <= prod_lo_q;                                   // RULE9
            end
         endcase
      end
   end

   // Flags: a multiply cycle never touches them, even if a stray flag write arrives
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         status_q <= `BHM_STATUS_RST;
      end else if (I_FLAG_WE && !I_MUL_EN) begin
         status_q <= I_FLAG_D;                                           // RULE3
      end
   end

   // Completion strobe, one cycle after the request
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         done_q <= 1'b0;
      end else begin
         done_q <= I_MUL_EN;                                             // RULE1
      end
   end

   assign O_PRODUCT_HIGH_BYTE = prod_hi_q;
   assign O_PRODUCT_LOW_BYTE  = prod_lo_q;
   assign O_ARITH_STATUS      = status_q;
   assign O_MUL_DONE          = done_q;

   // Reference product for the checks below, independent of the array
   logic [`BHM_PROD_W-1:0] ref_prod;
   assign ref_prod = `BHM_PROD_W'(I_WORK_REG) * `BHM_PROD_W'(I_FILE_OPND);

   // All checks run on the one system clock and sleep while reset is held
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);

   AST_PROD_PAIR: assert property (                                    // RULE1
      I_MUL_EN |=> {O_PRODUCT_HIGH_BYTE, O_PRODUCT_LOW_BYTE} == $past(ref_prod)
   ) else $error("Product pair wrong one cycle after multiply");

   AST_DONE_PULSE: assert property (                                   // RULE1
      I_MUL_EN ##1 !I_MUL_EN |=> !O_MUL_DONE
   ) else $error("Done strobe stretched beyond one cycle");

   AST_HI_BYTE: assert property (                                      // RULE2
      I_MUL_EN |=> O_PRODUCT_HIGH_BYTE == $past(ref_prod[`BHM_HI_MSB:`BHM_HI_LSB])
   ) else $error("High product byte does not hold upper product bits");

   AST_LO_BYTE: assert property (                                      // RULE2
      I_MUL_EN |=> O_PRODUCT_LOW_BYTE == $past(ref_prod[`BHM_LO_MSB:`BHM_LO_LSB])
   ) else $error("Low product byte does not hold lower product bits");

   AST_FLAGS_KEPT: assert property (                                   // RULE3
      I_MUL_EN |=> $stable(O_ARITH_STATUS)
   ) else $error("Status flags changed by a multiply");

   AST_WORK_OPERAND: assert property (                                 // RULE4
      (I_MUL_EN && I_FILE_OPND == 8'h01)
         |=> (O_PRODUCT_LOW_BYTE == $past(I_WORK_REG)) && (O_PRODUCT_HIGH_BYTE == 8'h00)
   ) else $error("Working register not used as multiply operand");

   AST_UNSIGNED: assert property (                                     // RULE8
      (I_MUL_EN && I_WORK_REG[`BHM_SIGN_BIT] && I_FILE_OPND[`BHM_SIGN_BIT])
         |=> O_PRODUCT_HIGH_BYTE >= 8'h40
   ) else $error("Operands with top bit set treated as signed");

   AST_HOLD: assert property (                                         // RULE9
      (!I_MUL_EN && !I_PROD_HI_WE && !I_PROD_LO_WE) [*2]
         |=> $stable(O_PRODUCT_HIGH_BYTE) && $stable(O_PRODUCT_LOW_BYTE)
   ) else $error("Product pair changed without multiply or write");

   AST_SW_WRITE: assert property (                                     // RULE9
      (!I_MUL_EN && I_PROD_HI_WE && !I_PROD_LO_WE)
         |=> (O_PRODUCT_HIGH_BYTE == $past(I_WR_DATA)) && $stable(O_PRODUCT_LOW_BYTE)
   ) else $error("High byte write failed or disturbed low byte");

   AST_DONE_RISE: assert property (                                    // RULE1
      I_MUL_EN |=> O_MUL_DONE
   ) else $error("Done strobe missing after multiply");

   AST_DONE_IDLE: assert property (                                    // RULE1
      !I_MUL_EN |=> !O_MUL_DONE
   ) else $error("Done strobe without a multiply");

   // Checked every cycle so an adder chain fault shows before a register hides it
   AST_ARRAY_MATCH: assert property (                                  // RULE1
      mif.product == ref_prod
   ) else $error("Array product differs from plain multiply");

   AST_MUL_WINS: assert property (                                     // RULE2
      (I_MUL_EN && (I_PROD_HI_WE || I_PROD_LO_WE))
         |=> {O_PRODUCT_HIGH_BYTE, O_PRODUCT_LOW_BYTE} == $past(ref_prod)
   ) else $error("Software write overrode a multiply");

   AST_FLAG_UPDATE: assert property (                                  // RULE3
      (I_FLAG_WE && !I_MUL_EN) |=> O_ARITH_STATUS == $past(I_FLAG_D)
   ) else $error("Status flag update lost outside a multiply");

   AST_STATUS_HOLD: assert property (                                  // RULE3
      !I_FLAG_WE |=> $stable(O_ARITH_STATUS)
   ) else $error("Status flags changed without an update");

   AST_ZERO_WORK: assert property (                                    // RULE4
      (I_MUL_EN && I_WORK_REG == 8'h00)
         |=> (O_PRODUCT_HIGH_BYTE == 8'h00) && (O_PRODUCT_LOW_BYTE == 8'h00)
   ) else $error("Zero working register gave a nonzero product");

   AST_LO_WRITE: assert property (                                     // RULE9
      (!I_MUL_EN && I_PROD_LO_WE && !I_PROD_HI_WE)
         |=> (O_PRODUCT_LOW_BYTE == $past(I_WR_DATA)) && $stable(O_PRODUCT_HIGH_BYTE)
   ) else $error("Low byte write failed or disturbed high byte");

   AST_BOTH_WRITE: assert property (                                   // RULE9
      (!I_MUL_EN && I_PROD_HI_WE && I_PROD_LO_WE)
         |=> (O_PRODUCT_HIGH_BYTE == $past(I_WR_DATA))
             && (O_PRODUCT_LOW_BYTE == $past(I_WR_DATA))
   ) else $error("Dual byte write did not load both bytes");

   // Main scenarios: multiply, back to back, contention, dual write, sign bits
   CV_MUL: cover property (I_MUL_EN ##1 O_MUL_DONE);
   CV_BACK_TO_BACK: cover property (I_MUL_EN [*2]);
   CV_MUL_VS_WRITE: cover property (I_MUL_EN && I_PROD_HI_WE && I_FLAG_WE);
   CV_SW_BOTH: cover property (!I_MUL_EN && I_PROD_HI_WE && I_PROD_LO_WE);
   CV_SIGN_BITS: cover property (I_MUL_EN && I_WORK_REG[`BHM_SIGN_BIT] && I_FILE_OPND[`BHM_SIGN_BIT]);

endmodule

// [logic/bhm_defs.svh]
// Constants of the byte hardware multiplier: widths, byte fields, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BHM_DEFS_SVH
`define BHM_DEFS_SVH

// Operand and product widths
`define BHM_OPND_W      8
`define BHM_PROD_W      16

// Byte fields of the product pair
`define BHM_HI_MSB      15
`define BHM_HI_LSB      8
`define BHM_LO_MSB      7
`define BHM_LO_LSB      0

// Sign bit of an operand
`define BHM_SIGN_BIT    7

// Reset values
`define BHM_BYTE_RST    8'h00
`define BHM_STATUS_RST  8'h00

`endif

// [logic/bhm_pkg.sv]
// Types shared by the byte hardware multiplier modules.
// Assumes bhm_defs.svh is on the include path.
`include "bhm_defs.svh"

package bhm_pkg;

   // Where a product byte takes its next value from
   typedef enum logic [1:0] {
      BHM_SRC_HOLD = 2'h0,
      BHM_SRC_MUL  = 2'h1,
      BHM_SRC_SW   = 2'h3
   } bhm_src_t;

   typedef logic [`BHM_OPND_W-1:0] bhm_byte_t;
   typedef logic [`BHM_PROD_W-1:0] bhm_prod_t;

   // A multiply outranks a software byte write in the same cycle
   function automatic bhm_src_t bhm_byte_src(input logic mul, input logic we);
      bhm_src_t src;
      src = BHM_SRC_HOLD;
      if (mul) begin
         src = BHM_SRC_MUL;
      end else if (we) begin
         src = BHM_SRC_SW;
      end
      return src;
   endfunction

endpackage

// [logic/bhm_mul_if.sv]
// Carrier between the multiplier top and its array: operands out, product back.
// Assumes both ends share one clock; the path is purely combinational.
`timescale 1ns/1ps

interface bhm_mul_if #(
   parameter int W = 8
);
   logic [W-1:0]   opnd_a;
   logic [W-1:0]   opnd_b;
   logic [2*W-1:0] product;

   modport core  (output opnd_a, output opnd_b, input product);
   modport array (input opnd_a, input opnd_b, output product);
endinterface

// [logic/bhm_mul_array.sv]
// Unsigned shift-and-add multiplier array, combinational.
// Assumes the caller registers the product; depth is W adders in a chain.
`timescale 1ns/1ps

module bhm_mul_array
   import bhm_pkg::*;
#(
   parameter int W = 8
) (
   // Operands and product
   bhm_mul_if.array mif
);

   logic [2*W-1:0] pp  [W];
   logic [2*W-1:0] acc [W+1];

   assign acc[0] = '0;

   // Plain zero extension: no operand is ever treated as signed
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_row
         assign pp[gi]    = mif.opnd_b[gi] ? ({{W{1'b0}}, mif.opnd_a} << gi) : '0; // RULE8
         assign acc[gi+1] = acc[gi] + pp[gi];
      end
   endgenerate

   assign mif.product = acc[W];

endmodule

// [verification/bhm_core_model.sv]
// Core-side model: issues multiplies, product byte writes, flag updates.
// Assumes calls start at a falling edge after reset; drives on falling edges.
`timescale 1ns/1ps

module bhm_core_model
   import bhm_pkg::*;
(
   // Clock and product readback
   input  wire logic      i_clk,
   input  wire bhm_byte_t i_hi,
   input  wire bhm_byte_t i_lo,
   // Requests
   output logic           o_mul,
   output bhm_byte_t      o_work,
   output bhm_byte_t      o_file,
   output logic           o_hi_we,
   output logic           o_lo_we,
   output bhm_byte_t      o_wdata,
   output logic           o_flag_we,
   output bhm_byte_t      o_flag_d
);
   initial begin
      {o_mul, o_hi_we, o_lo_we, o_flag_we} = 4'h0;
      {o_work, o_file, o_wdata, o_flag_d} = 32'h5A5A_A5A5;
   end

   // Write data follows a, flag data follows b; idle lines turn over so stale data is not seen
   task automatic req(input logic m, input bhm_byte_t a, input bhm_byte_t b,
                      input logic [2:0] we, output bhm_prod_t p);
      o_mul = m;
      o_work = a;
      o_file = b;
      {o_hi_we, o_lo_we, o_flag_we} = we;
      o_wdata = a;
      o_flag_d = b;
      @(negedge i_clk);
      {o_mul, o_hi_we, o_lo_we, o_flag_we} = 4'h0;
      {o_work, o_file, o_wdata, o_flag_d} = ~{a, b, a, b};
      p = {i_hi, i_lo};
      @(negedge i_clk);
   endtask

   task automatic smul(input bhm_byte_t a, input bhm_byte_t b, output bhm_prod_t p);
      req(1'b1, a, b, 3'h0, p);
      p[15:8] = p[15:8] - (b[7] ? a : 8'h00) - (a[7] ? b : 8'h00);
   endtask

   // Four partial products; the product pair is only read just after each multiply
   task automatic wmul(input logic sgn, input bhm_prod_t a, input bhm_prod_t b,
                       output logic [31:0] r);
      bhm_prod_t ll, hh, lh, hl;
      req(1'b1, a[7:0], b[7:0], 3'h0, ll);
      req(1'b1, a[15:8], b[15:8], 3'h0, hh);
      req(1'b1, a[7:0], b[15:8], 3'h0, lh);
      req(1'b1, a[15:8], b[7:0], 3'h0, hl);
      r = {hh, ll} + {8'h00, lh, 8'h00} + {8'h00, hl, 8'h00};
      r[31:16] = r[31:16] - ((sgn && b[15]) ? a : 16'h0000);
      r[31:16] = r[31:16] - ((sgn && a[15]) ? b : 16'h0000);
   endtask
endmodule

// [verification/tb.sv]
// Self-checking bench of the byte hardware multiplier.
// Assumes the core model owns every request input of the design.
`timescale 1ns/1ps

module tb;
   import bhm_pkg::*;
   logic        clk, rst, mul, hi_we, lo_we, flag_we, done;
   bhm_byte_t   work, file_opnd, wdata, flag_d, hi, lo, status;
   bhm_prod_t   p;
   logic [31:0] r;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          done_cnt = 0;

   bhm_top dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_MUL_EN(mul), .I_WORK_REG(work),
      .I_FILE_OPND(file_opnd), .I_PROD_HI_WE(hi_we), .I_PROD_LO_WE(lo_we),
      .I_WR_DATA(wdata), .I_FLAG_WE(flag_we), .I_FLAG_D(flag_d),
      .O_PRODUCT_HIGH_BYTE(hi), .O_PRODUCT_LOW_BYTE(lo), .O_ARITH_STATUS(status),
      .O_MUL_DONE(done));
   bhm_core_model core_u (.i_clk(clk), .i_hi(hi), .i_lo(lo), .o_mul(mul), .o_work(work),
      .o_file(file_opnd), .o_hi_we(hi_we), .o_lo_we(lo_we), .o_wdata(wdata),
      .o_flag_we(flag_we), .o_flag_d(flag_d));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // A run needs about 60 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         error_cnt++;
         stop_test();
      end
   end

   // Done pulses are counted away from the launching edge
   always @(negedge clk) begin
      if (done === 1'b1) begin
         done_cnt++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic t_unsigned();
      bhm_byte_t a [5] = '{8'hFF, 8'h80, 8'h00, 8'h0D, 8'h9C};
      bhm_byte_t b [5] = '{8'hFF, 8'h02, 8'hC3, 8'h0B, 8'h01};
      for (int i = 0; i < 5; i++) begin
         core_u.req(1'b1, a[i], b[i], 3'h0, p);
         chk({hi, lo}, 16'(a[i]) * b[i]);
         chk(p, 16'(a[i]) * b[i]);
      end
      core_u.req(1'b1, 8'h0D, 8'h0B, 3'h0, p);
      chk(done, 1'b0);
      repeat (3) @(negedge clk);
      chk({hi, lo, status}, 24'h008F_00);
      chk(done_cnt, 6);
   endtask

   task automatic t_flags_writes();
      core_u.req(1'b0, 8'h00, 8'hA5, 3'h1, p);
      core_u.req(1'b1, 8'h03, 8'h3C, 3'h1, p);
      chk({status, p}, 24'hA5_00B4);
      core_u.req(1'b0, 8'h12, 8'h00, 3'h4, p);
      chk(p, 16'h12B4);
      core_u.req(1'b0, 8'h34, 8'h00, 3'h2, p);
      chk(p, 16'h1234);
      core_u.req(1'b1, 8'h02, 8'h03, 3'h7, p);
      chk({status, p}, 24'hA5_0006);
      core_u.req(1'b0, 8'h5C, 8'h00, 3'h6, p);
      chk(p, 16'h5C5C);
   endtask

   // Mid-run reset clears a nonzero pair and status, then a multiply follows at once
   task automatic t_reset();
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk({hi, lo, status, 7'h00, done}, 32'h0000_0000);
      core_u.req(1'b1, 8'h11, 8'h11, 3'h0, p);
      chk({hi, lo, p}, 32'h0121_0121);
   endtask

   task automatic t_signed();
      core_u.smul(8'hFD, 8'h05, p);
      chk(p, 16'hFFF1);
      core_u.wmul(1'b0, 16'hFFFF, 16'hFFFF, r);
      chk(r, 32'hFFFE_0001);
      core_u.wmul(1'b1, 16'hFFFE, 16'h0003, r);
      chk(r, 32'hFFFF_FFFA);
   endtask

   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      chk({hi, lo, status, 7'h00, done}, 32'h0000_0000);
      t_unsigned();
      t_flags_writes();
      t_reset();
      t_signed();
      stop_test();
   end
endmodule
